// file: rps_sequencer.sv
// regulator power sequencer: registers, slot timer and regulator seven enable
// Operation
// - hold 8-bit voltage code; 1.500 V + (code-16)*8 mV, 00 default, 01-0F reserved.
// - slot select 000 leaves regulator seven to its manual enable bit.
// - slot select 1..7 enables regulator seven in that slot of power-up.
// - period field bits 7:6 gives 500 us, 1.0, 1.5, 2.0 ms slots.
// - writing command 01 starts power-up through slots ascending.
// - writing command 10 starts shutdown, slots descending ending with slot 1.
// - command 11 is ignored; 00 is the idle default.
// - command field self-clears to 00 and never reads back as written.
// - running flag in bit 3 is 1 from the start of the first slot (1 up, 7 down) while sequencing.
// - running flag stays set through all seven slots, empty or not.
// - current slot field bits 2:0 reads 1..7, or 000 when idle.
// - current slot field returns the slot in progress at read time.
module rps_sequencer #(
	parameter int SLOT_BASE = rps_pkg::SLOT_BASE_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// regulator seven control
	input wire logic reg7_manual_enable,
	output logic reg7_enable,
	output logic [7:0] reg7_voltage_code,
	output logic reg7_code_reserved
);
	import rps_pkg::*;

	// the slot timer holds 20 bits, so a base count beyond a million cannot be served
	if (SLOT_BASE < 1 || SLOT_BASE > 1_000_000) begin : g_slot_base_bad
		$error("slot base count out of range");
	end

	typedef struct packed {
		logic [7:0] vcode;
		logic [2:0] slot_sel;
		logic [1:0] period;
		rps_state_t state;
		logic [2:0] slot;
		logic [1:0] mult;
		logic [19:0] tick;
		logic seq_en;
		logic [7:0] rdata;
		logic [22:0] dwell;
		logic per_moved;
	} rps_regs_t;

	rps_regs_t r;
	rps_regs_t next_r;
	logic running;
	logic slot_end;

	assign running = (r.state != RPS_IDLE);
	// a slot lasts (period+1) base periods of 500 us
	assign slot_end = (r.tick == 20'(SLOT_BASE - 1)) && (r.mult == r.period);

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		next_r = r;
		if (reg_wr && reg_addr == OFS_REG7_OUTPUT_VOLTAGE_CODE) begin
			next_r.vcode = reg_wdata;
		end
		if (reg_wr && reg_addr == OFS_REG7_SEQUENCE_SLOT) begin
			next_r.slot_sel = reg_wdata[2:0];
		end
		if (reg_wr && reg_addr == OFS_SEQUENCER_CONTROL_STATUS) begin
			next_r.period = reg_wdata[POS_PERIOD +: 2];
		end
		// slot timer runs only while sequencing
		if (running) begin
			if (r.tick == 20'(SLOT_BASE - 1)) begin
				next_r.tick = '0;
				next_r.mult = (r.mult == r.period) ? 2'h0 : r.mult + 2'h1;
			end else begin
				next_r.tick = r.tick + 20'h1;
			end
		end
		// dwell count of the live slot, for the period check; a period write
		// while running voids that check for the rest of the slot
		if (r.state == RPS_IDLE || slot_end) begin
			next_r.dwell = '0;
			next_r.per_moved = 1'b0;
		end else begin
			next_r.dwell = r.dwell + 23'h1;
		end
		if (running && reg_wr && reg_addr == OFS_SEQUENCER_CONTROL_STATUS) begin
			next_r.per_moved = 1'b1;
		end
		case (r.state)
			RPS_IDLE: begin
				next_r.tick = '0;
				next_r.mult = 2'h0;
				next_r.slot = 3'h0;
				// command acts on write only, never stored
				if (reg_wr && reg_addr == OFS_SEQUENCER_CONTROL_STATUS) begin
					case (reg_wdata[POS_COMMAND +: 2])
						CMD_POWER_UP: begin
							next_r.state = RPS_UP;
							next_r.slot = SLOT_FIRST;
						end
						CMD_SHUTDOWN: begin
							next_r.state = RPS_DOWN;
							next_r.slot = SLOT_LAST;
						end
						default: begin
							next_r.state = RPS_IDLE;
						end
					endcase
				end
			end
			RPS_UP: begin
				// run all seven slots regardless of use
				if (slot_end) begin
					if (r.slot == SLOT_LAST) begin
						next_r.state = RPS_IDLE;
						next_r.slot = 3'h0;
					end else begin
						next_r.slot = r.slot + 3'h1;
					end
				end
			end
			RPS_DOWN: begin
				if (slot_end) begin
					if (r.slot == SLOT_FIRST) begin
						next_r.state = RPS_IDLE;
						next_r.slot = 3'h0;
					end else begin
						next_r.slot = r.slot - 3'h1;
					end
				end
			end
			default: begin
				next_r.state = RPS_IDLE;
				next_r.slot = 3'h0;
			end
		endcase
		// enable in the assigned power-up slot
		if (r.slot_sel != 3'h0 && r.state == RPS_UP && r.slot == r.slot_sel) begin
			next_r.seq_en = 1'b1;
		end
		// disable in the assigned shutdown slot
		if (r.slot_sel != 3'h0 && r.state == RPS_DOWN && r.slot == r.slot_sel) begin
			next_r.seq_en = 1'b0;
		end
		// read data, registered; unmapped offsets read zero
		next_r.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				OFS_REG7_OUTPUT_VOLTAGE_CODE: next_r.rdata = r.vcode;
				OFS_REG7_SEQUENCE_SLOT: next_r.rdata = {5'h00, r.slot_sel};
				// running flag; slot; slot live at read
				OFS_SEQUENCER_CONTROL_STATUS: next_r.rdata = {r.period, CMD_IDLE, running, r.slot};
				default: next_r.rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge mclk) begin
		if (srst) begin
			r <= '{vcode: RST_VOLTAGE_CODE, slot_sel: RST_SLOT_SELECT, period: RST_PERIOD_SELECT,
				state: RPS_IDLE, slot: 3'h0, mult: 2'h0, tick: 20'h0, seq_en: 1'b0, rdata: 8'h00,
				dwell: 23'h0, per_moved: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	// slot 000 hands control to the manual bit
	assign reg7_enable = (r.slot_sel == 3'h0) ? reg7_manual_enable : r.seq_en;
	assign reg7_voltage_code = r.vcode;
	// flag reserved codes so the analog side keeps its default
	assign reg7_code_reserved = (r.vcode != 8'h00) && (r.vcode < CODE_FIRST_VALID);
	assign reg_rdata = r.rdata;

	////////////////////////////////////////////////////////////////////////
	// assertions
	// power-up start
	AST_UP_START: assert property (@(posedge mclk) disable iff (srst)
		(r.state == RPS_IDLE && reg_wr && reg_addr == OFS_SEQUENCER_CONTROL_STATUS
		&& reg_wdata[5:4] == CMD_POWER_UP) |=> (r.state == RPS_UP && r.slot == 3'h1))
		else $error("power-up did not start in slot 1");

	AST_DOWN_START: assert property (@(posedge mclk) disable iff (srst)
		(r.state == RPS_IDLE && reg_wr && reg_addr == OFS_SEQUENCER_CONTROL_STATUS
		&& reg_wdata[5:4] == CMD_SHUTDOWN) |=> (r.state == RPS_DOWN && r.slot == 3'h7))
		else $error("shutdown did not start in slot 7");

	AST_IGNORE_11: assert property (@(posedge mclk) disable iff (srst)
		(r.state == RPS_IDLE && reg_wr && reg_addr == OFS_SEQUENCER_CONTROL_STATUS
		&& reg_wdata[5:4] == CMD_IGNORED) |=> r.state == RPS_IDLE)
		else $error("command 11 started a sequence");

	AST_IDLE_STAYS: assert property (@(posedge mclk) disable iff (srst)
		(r.state == RPS_IDLE && !(reg_wr && reg_addr == OFS_SEQUENCER_CONTROL_STATUS
		&& (reg_wdata[5:4] == CMD_POWER_UP || reg_wdata[5:4] == CMD_SHUTDOWN))) |=> r.state == RPS_IDLE)
		else $error("sequence started without a start command");

	AST_CMD_READS_ZERO: assert property (@(posedge mclk) disable iff (srst)
		$past(reg_rd) && $past(reg_addr) == OFS_SEQUENCER_CONTROL_STATUS |-> reg_rdata[5:4] == 2'h0)
		else $error("command field read back nonzero");

	AST_RUN_MATCHES_SLOT: assert property (@(posedge mclk) disable iff (srst)
		running == (r.slot != 3'h0))
		else $error("running flag and slot disagree");

	AST_STATUS_RUNNING: assert property (@(posedge mclk) disable iff (srst)
		(reg_rd && reg_addr == OFS_SEQUENCER_CONTROL_STATUS) |=> reg_rdata[3] == $past(running))
		else $error("running flag read is not the live state");

	AST_UP_STEP: assert property (@(posedge mclk) disable iff (srst)
		(r.state == RPS_UP && slot_end && r.slot != 3'h7) |=> (r.state == RPS_UP && r.slot == $past(r.slot) + 3'h1))
		else $error("power-up skipped a slot");

	AST_UP_END: assert property (@(posedge mclk) disable iff (srst)
		(r.state == RPS_UP && slot_end && r.slot == 3'h7) |=> (r.state == RPS_IDLE && r.slot == 3'h0))
		else $error("power-up did not finish after slot 7");

	AST_DOWN_END: assert property (@(posedge mclk) disable iff (srst)
		(r.state == RPS_DOWN && slot_end && r.slot == 3'h1) |=> r.state == RPS_IDLE)
		else $error("shutdown did not finish after slot 1");

	AST_DOWN_STEP: assert property (@(posedge mclk) disable iff (srst)
		(r.state == RPS_DOWN && slot_end && r.slot != 3'h1)
		|=> (r.state == RPS_DOWN && r.slot == $past(r.slot) - 3'h1))
		else $error("shutdown skipped a slot");

	AST_BUSY_KEEPS_RUN: assert property (@(posedge mclk) disable iff (srst)
		(running && !slot_end) |=> (r.state == $past(r.state)))
		else $error("sequence left its state before the slot ended");

	AST_SLOT_HOLD: assert property (@(posedge mclk) disable iff (srst)
		(running && !slot_end) |=> $stable(r.slot))
		else $error("slot moved before its period ran out");

	AST_SLOT_READ: assert property (@(posedge mclk) disable iff (srst)
		(reg_rd && reg_addr == OFS_SEQUENCER_CONTROL_STATUS) |=> reg_rdata[2:0] == $past(r.slot))
		else $error("slot read is not the live slot");

	AST_RDATA_QUIET: assert property (@(posedge mclk) disable iff (srst)
		!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data present without a read");

	AST_MANUAL: assert property (@(posedge mclk) disable iff (srst)
		r.slot_sel == 3'h0 |-> reg7_enable == reg7_manual_enable)
		else $error("manual enable not followed");

	AST_UP_ENABLE: assert property (@(posedge mclk) disable iff (srst)
		(r.state == RPS_UP && r.slot_sel != 3'h0 && r.slot == r.slot_sel) |=> reg7_enable)
		else $error("regulator not enabled in its slot");

	AST_DOWN_DISABLE: assert property (@(posedge mclk) disable iff (srst)
		(r.state == RPS_DOWN && r.slot_sel != 3'h0 && r.slot == r.slot_sel) |=> !reg7_enable)
		else $error("regulator not disabled in its slot");

	AST_SLOT_SEL_WRITE: assert property (@(posedge mclk) disable iff (srst)
		(reg_wr && reg_addr == OFS_REG7_SEQUENCE_SLOT) |=> r.slot_sel == $past(reg_wdata[2:0]))
		else $error("slot select write lost");

	AST_PERIOD_WRITE: assert property (@(posedge mclk) disable iff (srst)
		(reg_wr && reg_addr == OFS_SEQUENCER_CONTROL_STATUS) |=> r.period == $past(reg_wdata[7:6]))
		else $error("period write lost");

	AST_PERIOD: assert property (@(posedge mclk) disable iff (srst)
		(running && slot_end && !r.per_moved) |-> r.dwell == 23'((r.period + 3'h1) * SLOT_BASE - 1))
		else $error("slot length does not match the period code");

	AST_VCODE_WRITE: assert property (@(posedge mclk) disable iff (srst)
		(reg_wr && reg_addr == OFS_REG7_OUTPUT_VOLTAGE_CODE) |=> reg7_voltage_code == $past(reg_wdata))
		else $error("voltage code write lost");

	AST_CODE_RESERVED: assert property (@(posedge mclk) disable iff (srst)
		reg7_code_reserved == (r.vcode[7:4] == 4'h0 && r.vcode != 8'h00))
		else $error("reserved flag disagrees with code");
endmodule : rps_sequencer

// file: rps_pkg.sv
// package for the regulator power sequencer: offsets, fields, reset values, timing
package rps_pkg;
	// register offsets
	localparam logic [7:0] OFS_REG7_OUTPUT_VOLTAGE_CODE = 8'h0A;
	localparam logic [7:0] OFS_REG7_SEQUENCE_SLOT = 8'h0E;
	localparam logic [7:0] OFS_SEQUENCER_CONTROL_STATUS = 8'h0F;
	// reset values
	localparam logic [7:0] RST_VOLTAGE_CODE = 8'h00;
	localparam logic [2:0] RST_SLOT_SELECT = 3'h0;
	localparam logic [1:0] RST_PERIOD_SELECT = 2'h0;
	// field positions in the control/status register
	localparam int POS_PERIOD = 6;
	localparam int POS_COMMAND = 4;
	localparam int POS_RUNNING = 3;
	localparam int POS_SLOT = 0;
	// command codes
	localparam logic [1:0] CMD_IDLE = 2'h0;
	localparam logic [1:0] CMD_POWER_UP = 2'h1;
	localparam logic [1:0] CMD_SHUTDOWN = 2'h2;
	localparam logic [1:0] CMD_IGNORED = 2'h3;
	// voltage code limits: 00 default, 01..0F reserved
	localparam logic [7:0] CODE_FIRST_VALID = 8'h10;
	localparam logic [2:0] SLOT_FIRST = 3'h1;
	localparam logic [2:0] SLOT_LAST = 3'h7;
	// timing
	localparam int CLK_FREQ_HZ = 40_000_000;
	localparam int SLOT_BASE_US = 500;
	localparam int SLOT_BASE_CYCLES = SLOT_BASE_US * (CLK_FREQ_HZ / 1_000_000);
	// sequencer states, gray along idle -> up -> idle
	typedef enum logic [1:0] {
		RPS_IDLE = 2'b00,
		RPS_UP = 2'b01,
		RPS_DOWN = 2'b10
	} rps_state_t;
endpackage : rps_pkg

// file: rps_host.sv
// host model: register cycles towards the sequencer
module rps_host (
	// clock
	input wire logic mclk,
	// register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	////////////////////////////////////////////////////////////
	// one write; released lines show inverted data, not stale data
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~v;
	endtask : wr
	// one read; data stands in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		v = reg_rdata;
	endtask : rd
	task automatic cmd(input logic [7:0] v);
		logic [7:0] s;
		s = 8'hFF;
		for (int i = 0; i < 400 && s[3] !== 1'b0; i++) rd(8'h0F, s);
		wr(8'h0F, v);
	endtask : cmd
endmodule : rps_host

// file: rps_sequencer_test.sv
// self-checking bench for the sequencer, driven by the host model
module rps_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	import rps_pkg::*;
	localparam int BASE = 4;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic man_en = 1'b0;
	logic reg_wr, reg_rd, reg7_enable, reg7_code_reserved;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, reg7_voltage_code, d, v;
	logic [7:0] offs [4] = '{8'h0A, 8'h0E, 8'h0F, 8'h20};
	logic [1:0] p = 2'h0;
	int n_errors = 0;
	int n_tests = 0;
	// 40 MHz clock
	always #12.5 mclk = ~mclk;
	rps_sequencer #(.SLOT_BASE(BASE)) rps_sequencer_inst (.mclk(mclk), .srst(srst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg7_manual_enable(man_en), .reg7_enable(reg7_enable), .reg7_voltage_code(reg7_voltage_code),
		.reg7_code_reserved(reg7_code_reserved));
	rps_host rps_host_inst (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// expected status byte: period, command reads 00, running flag, slot
	function automatic logic [7:0] exp_status(input logic [1:0] per, input logic run_flag, input logic [2:0] slot);
		return {per, 2'b00, run_flag, slot};
	endfunction : exp_status
	task automatic report_and_stop;
		$display("errors %0d of %0d checks", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// one sequence: follow the slot field by polling, time it by read count
	task automatic run(input logic [1:0] c, input logic [2:0] s);
		int n;
		int t;
		logic [2:0] prev;
		n = 0;
		t = 7 * (p + 1) * BASE;
		rps_host_inst.cmd({p, c, 4'h0});
		rps_host_inst.rd(OFS_SEQUENCER_CONTROL_STATUS, d);
		prev = d[2:0];
		chk(d, exp_status(p, 1'b1, (c == CMD_POWER_UP) ? SLOT_FIRST : SLOT_LAST));
		while (d[3] === 1'b1 && n < 400) begin
			n++;
			chk({4'h0, d[7:4]}, {4'h0, p, 2'b00});
			if (d[2:0] !== s) chk({7'h0, reg7_enable}, {7'h0, d[2:0] > s});
			if (d[2:0] !== prev) chk({5'h0, d[2:0]}, {5'h0, (c == CMD_POWER_UP) ? prev + 3'h1 : prev - 3'h1});
			prev = d[2:0];
			rps_host_inst.rd(OFS_SEQUENCER_CONTROL_STATUS, d);
		end
		chk(d, exp_status(p, 1'b0, 3'h0));
		chk({5'h0, prev}, {5'h0, (c == CMD_POWER_UP) ? SLOT_LAST : SLOT_FIRST});
		chk({7'h0, reg7_enable}, {7'h0, c == CMD_POWER_UP});
		chk({7'h0, 2 * n > t - 9 && 2 * n < t + 3}, 8'h01);
	endtask : run
	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(90371));
		repeat (5) @(posedge mclk);
		#1;
		srst = 1'b0;
		// reset values, unmapped place reads zero
		for (int i = 0; i < 4; i++) begin
			rps_host_inst.rd(offs[i], d);
			chk(d, 8'h00);
		end
		// command 00 only moves the period; an unmapped write is dropped
		rps_host_inst.wr(OFS_SEQUENCER_CONTROL_STATUS, {2'h2, CMD_IDLE, 4'hF});
		rps_host_inst.rd(OFS_SEQUENCER_CONTROL_STATUS, d);
		chk(d, exp_status(2'h2, 1'b0, 3'h0));
		rps_host_inst.wr(8'h20, 8'($urandom));
		rps_host_inst.rd(8'h20, d);
		chk(d, 8'h00);
		for (int i = 0; i < 10; i++) begin
			v = (i == 0) ? 8'h0F : (i == 1) ? 8'h10 : 8'($urandom);
			rps_host_inst.wr(OFS_REG7_OUTPUT_VOLTAGE_CODE, v);
			rps_host_inst.rd(OFS_REG7_OUTPUT_VOLTAGE_CODE, d);
			chk(d, v);
			chk(reg7_voltage_code, v);
			chk({7'h0, reg7_code_reserved}, {7'h0, v != 8'h00 && v < CODE_FIRST_VALID});
		end
		// manual control with slot select zero
		for (int i = 0; i < 4; i++) begin
			man_en = 1'($urandom);
			@(posedge mclk);
			#1;
			chk({7'h0, reg7_enable}, {7'h0, man_en});
		end
		man_en = 1'b0;
		// every slot, random period, up, ignored code, down
		for (int s = 1; s < 8; s++) begin
			p = 2'($urandom);
			rps_host_inst.wr(OFS_REG7_SEQUENCE_SLOT, 8'(s));
			rps_host_inst.rd(OFS_REG7_SEQUENCE_SLOT, d);
			chk(d, 8'(s));
			run(CMD_POWER_UP, 3'(s));
			rps_host_inst.wr(OFS_SEQUENCER_CONTROL_STATUS, {p, CMD_IGNORED, 4'h0});
			rps_host_inst.rd(OFS_SEQUENCER_CONTROL_STATUS, d);
			chk(d, exp_status(p, 1'b0, 3'h0));
			run(CMD_SHUTDOWN, 3'(s));
		end
		report_and_stop;
	end
	// watchdog: under two thousand cycles are needed, twenty thousand allowed
	initial begin
		#(25 * 20000);
		n_errors++;
		report_and_stop;
	end
endmodule : rps_sequencer_test
